// ### design/vfc_defs.vh
`ifndef VFC_DEFS_VH
`define VFC_DEFS_VH
// ****************************************
// Serial port addresses
// ****************************************
`define VFC_I2C_ADDR_LO  7'h20
`define VFC_I2C_ADDR_HI  7'h21
// ****************************************
// Register indexes
// ****************************************
`define VFC_REG_INPUT    8'h00
`define VFC_REG_CTRL     8'h01
`define VFC_REG_MGAIN    8'h02
`define VFC_REG_MCLAMP   8'h03
`define VFC_REG_STATUS   8'h04
`define VFC_REG_GAIN     8'h05
`define VFC_REG_ID       8'h06
// ****************************************
// Field positions
// ****************************************
`define VFC_CHAN_LSB     0
`define VFC_FMT_LSB      4
`define VFC_AGC_BYP_BIT  0
`define VFC_CLP_BYP_BIT  1
`define VFC_DITHER_BIT   2
// ****************************************
// Reset values and codes
// ****************************************
`define VFC_INPUT_RST    8'h00
`define VFC_CTRL_RST     8'h00
`define VFC_MGAIN_RST    8'h40
`define VFC_MCLAMP_RST   8'h10
`define VFC_ID_VAL       8'h5A
`define VFC_FMT_CVBS     2'h0
`define VFC_FMT_YC       2'h1
`define VFC_FMT_YPRPB    2'h2
`define VFC_MULT_CVBS    4'h2
`define VFC_MULT_YC      4'h4
`define VFC_MULT_YPRPB   4'h6
`define VFC_STD_NONE     2'h0
`define VFC_STD_NTSC     2'h1
`define VFC_STD_PAL      2'h2
`define VFC_STD_SECAM    2'h3
`define VFC_LINES_625    10'h23F
`define VFC_AGC_TARGET   10'h320
`define VFC_BLACK_LEVEL  10'h040
`define VFC_GAIN_UNITY   8'h40
// ****************************************
// Timing
// ****************************************
`define VFC_SETTLE_CYC   7'd100
`endif

// ### design/vfc_sync.v
`timescale 1ns/1ps
`default_nettype none
module vfc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

// ### design/vfc_dither.v
`timescale 1ns/1ps
`default_nettype none
module vfc_dither (
  input  wire       clk,
  input  wire       rstn,
  input  wire       step,
  input  wire [7:0] din,
  output wire [5:0] dout
);
  reg  [7:0] lfsr_q;
  wire [8:0] sum;

  // ****************************************
  // Noise source
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_q <= 8'hA5;
    end else if (step) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // Add noise below kept bits, truncate, saturate
  assign sum  = {1'b0, din} + {7'h00, lfsr_q[1:0]};
  assign dout = sum[8] ? 6'h3F : sum[7:2];
endmodule
`default_nettype wire

// ### design/vfc_top.v
// What this block does
// RULE_01 - Host holds reset low five milliseconds; the bench holds it low 20 cycles
// RULE_02 - Answer serial address 0x40 or 0x42
// RULE_03 - Host serial clock at most 400 kHz
// RULE_04 - Low power-down pin enters power-down mode
// RULE_05 - Sampling clock rate chosen by input format
// RULE_06 - All rates derived from crystal reference
// RULE_07 - Mux routes one of eight channels
// RULE_08 - One 10-bit converter digitizes signal
// RULE_09 - Gain and clamp control bypassable manually
// RULE_10 - Digital fine clamp after the converter
// RULE_11 - Output is 8-bit YCrCb 4:2:2 stream
// RULE_12 - Down-dither reduces samples to 6 bits
// RULE_13 - Detect NTSC, PAL or SECAM automatically
// RULE_14 - Host waits five milliseconds before transactions; the bench waits 500 cycles before its serial transactions
// RULE_15 - Format change reselects clock before resuming
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`include "vfc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module vfc_top (
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  input  wire       scl_pin,
  input  wire       serial_data_pin_i,
  output reg        serial_data_pin_o_q,
  output reg        serial_data_pin_oe_q,
  input  wire       address_select_pin,
  input  wire       power_down_pin_n,
  output reg  [2:0] chan_sel_q,
  output reg  [1:0] adc_clk_sel_q,
  output reg  [3:0] ref_mult_q,
  output reg        adc_run_q,
  input  wire [9:0] adc_sample,
  input  wire       adc_valid,
  output reg  [9:0] afe_data_q,
  output reg        afe_valid_q,
  input  wire       line_sync,
  input  wire       field_sync,
  input  wire       secam_carrier,
  input  wire [7:0] y_in,
  input  wire [7:0] c_in,
  input  wire       pix_valid,
  output reg  [7:0] vid_data_q,
  output reg        vid_valid_q,
  output reg        vid_luma_q,
  output reg        power_down_q
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_SUB  = 3'h2;
  localparam S_WR   = 3'h3;
  localparam S_RD   = 3'h4;

  reg  [7:0] input_q;
  reg  [7:0] ctrl_q;
  reg  [7:0] mgain_q;
  reg  [7:0] mclamp_q;
  reg  [7:0] gain_q;
  reg  [9:0] clamp_q;
  reg  [9:0] peak_q;
  reg  [9:0] floor_q;
  reg  [1:0] std_q;
  reg  [9:0] lines_q;
  reg  [6:0] settle_q;
  reg  [1:0] fmt_seen_q;
  reg  [2:0] ist_q;
  reg  [3:0] icnt_q;
  reg  [7:0] ish_q;
  reg  [7:0] itx_q;
  reg  [7:0] isub_q;
  reg        irw_q;
  reg        in_ack_q;
  reg        mack_q;
  reg        scl_d_q;
  reg        sda_d_q;
  reg        iwe_q;
  reg  [7:0] iwaddr_q;
  reg  [7:0] iwdata_q;
  reg  [7:0] pend_y_q;
  reg        pend_q;
  reg        cr_q;
  wire [3:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       pd_n_s;
  wire       address_select_pin_s;
  wire [1:0] fmt;
  wire [6:0] my_addr;
  wire       start_c;
  wire       stop_c;
  wire       scl_rise;
  wire       scl_fall;
  wire       wr_en;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire [17:0] prod;
  wire [9:0] gained;
  wire [9:0] clamp_use;
  wire [5:0] dith6;
  wire [7:0] fmt_byte;

  // ****************************************
  // Helpers
  // ****************************************
  function [3:0] fmt_mult;
    input [1:0] f;
    begin
      case (f)
        `VFC_FMT_YC:    fmt_mult = `VFC_MULT_YC;
        `VFC_FMT_YPRPB: fmt_mult = `VFC_MULT_YPRPB;
        default:        fmt_mult = `VFC_MULT_CVBS;
      endcase
    end
  endfunction

  function [9:0] sat_sub;
    input [9:0] a;
    input [9:0] b;
    input [9:0] c;
    reg   [11:0] t;
    begin
      t = {2'b00, a} - {2'b00, b} + {2'b00, c};
      if (t[11]) begin
        sat_sub = 10'h000;
      end else if (t[10]) begin
        sat_sub = 10'h3FF;
      end else begin
        sat_sub = t[9:0];
      end
    end
  endfunction

  function [7:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `VFC_REG_INPUT:  reg_read = input_q;
        `VFC_REG_CTRL:   reg_read = ctrl_q;
        `VFC_REG_MGAIN:  reg_read = mgain_q;
        `VFC_REG_MCLAMP: reg_read = mclamp_q;
        `VFC_REG_STATUS: reg_read = {2'b00, adc_clk_sel_q, adc_run_q,
                                     power_down_q, std_q};
        `VFC_REG_GAIN:   reg_read = gain_q;
        `VFC_REG_ID:     reg_read = `VFC_ID_VAL;
        default:         reg_read = 8'h00;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  vfc_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({scl_pin, serial_data_pin_i, power_down_pin_n, address_select_pin}),
    .dout (pins_s)
  );

  assign scl_s   = pins_s[3];
  assign sda_s   = pins_s[2];
  assign pd_n_s  = pins_s[1];
  assign address_select_pin_s  = pins_s[0];
  assign my_addr = address_select_pin_s ? `VFC_I2C_ADDR_HI : `VFC_I2C_ADDR_LO; // [RULE_02]
  assign fmt     = input_q[`VFC_FMT_LSB +: 2];

  // ****************************************
  // Serial port slave
  // ****************************************
  assign start_c  = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_c   = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_q              <= 1'b1;
      sda_d_q              <= 1'b1;
      ist_q                <= S_IDLE;
      icnt_q               <= 4'h0;
      ish_q                <= 8'h00;
      itx_q                <= 8'h00;
      isub_q               <= 8'h00;
      irw_q                <= 1'b0;
      in_ack_q             <= 1'b0;
      mack_q               <= 1'b1;
      iwe_q                <= 1'b0;
      iwaddr_q             <= 8'h00;
      iwdata_q             <= 8'h00;
      serial_data_pin_o_q  <= 1'b0;
      serial_data_pin_oe_q <= 1'b0;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
      iwe_q   <= 1'b0;
      if (start_c) begin
        ist_q                <= S_ADDR;
        icnt_q               <= 4'h0;
        in_ack_q             <= 1'b0;
        serial_data_pin_oe_q <= 1'b0;
      end else if (stop_c) begin
        ist_q                <= S_IDLE;
        serial_data_pin_oe_q <= 1'b0;
      end else if (ist_q != S_IDLE) begin
        if (scl_rise) begin
          if (icnt_q == 4'h8) begin
            icnt_q   <= 4'h0;
            in_ack_q <= 1'b1;
            mack_q   <= sda_s;
          end else begin
            icnt_q <= icnt_q + 4'h1;
            ish_q  <= {ish_q[6:0], sda_s};
          end
        end else if (scl_fall) begin
          if (icnt_q == 4'h8) begin
            serial_data_pin_oe_q <= 1'b0;
            case (ist_q)
              S_ADDR: begin
                if (ish_q[7:1] == my_addr) begin // [RULE_02]
                  irw_q                <= ish_q[0];
                  serial_data_pin_oe_q <= 1'b1;
                end else begin
                  ist_q <= S_IDLE;
                end
              end
              S_SUB: begin
                isub_q               <= ish_q;
                serial_data_pin_oe_q <= 1'b1;
              end
              S_WR: begin
                iwe_q                <= 1'b1;
                iwaddr_q             <= isub_q;
                iwdata_q             <= ish_q;
                isub_q               <= isub_q + 8'h01;
                serial_data_pin_oe_q <= 1'b1;
              end
              default: begin
                serial_data_pin_oe_q <= 1'b0;
              end
            endcase
          end else if (in_ack_q) begin
            in_ack_q <= 1'b0;
            case (ist_q)
              S_ADDR: begin
                if (irw_q) begin
                  ist_q                <= S_RD;
                  itx_q                <= reg_read(isub_q);
                  isub_q               <= isub_q + 8'h01;
                  serial_data_pin_oe_q <= (reg_read(isub_q) < 8'h80);
                end else begin
                  ist_q                <= S_SUB;
                  serial_data_pin_oe_q <= 1'b0;
                end
              end
              S_SUB: begin
                ist_q                <= S_WR;
                serial_data_pin_oe_q <= 1'b0;
              end
              S_RD: begin
                if (!mack_q) begin
                  itx_q                <= reg_read(isub_q);
                  isub_q               <= isub_q + 8'h01;
                  serial_data_pin_oe_q <= (reg_read(isub_q) < 8'h80);
                end else begin
                  ist_q                <= S_IDLE;
                  serial_data_pin_oe_q <= 1'b0;
                end
              end
              default: begin
                serial_data_pin_oe_q <= 1'b0;
              end
            endcase
          end else if (ist_q == S_RD) begin
            itx_q                <= {itx_q[6:0], 1'b0};
            serial_data_pin_oe_q <= ~itx_q[6];
          end
        end
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  assign wr_en   = reg_wr | iwe_q;
  assign wr_addr = reg_wr ? reg_addr : iwaddr_q;
  assign wr_data = reg_wr ? reg_wdata : iwdata_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      input_q     <= `VFC_INPUT_RST;
      ctrl_q      <= `VFC_CTRL_RST;
      mgain_q     <= `VFC_MGAIN_RST;
      mclamp_q    <= `VFC_MCLAMP_RST;
      reg_rdata_q <= 8'h00;
    end else begin
      if (wr_en) begin
        case (wr_addr)
          `VFC_REG_INPUT:  input_q  <= wr_data;
          `VFC_REG_CTRL:   ctrl_q   <= wr_data;
          `VFC_REG_MGAIN:  mgain_q  <= wr_data;
          `VFC_REG_MCLAMP: mclamp_q <= wr_data;
          default:         input_q  <= input_q;
        endcase
      end
      reg_rdata_q <= reg_rd ? reg_read(reg_addr) : 8'h00;
    end
  end

  // ****************************************
  // Power-down, mux and sampling clock
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_down_q  <= 1'b1;
      chan_sel_q    <= 3'h0;
      adc_clk_sel_q <= `VFC_FMT_CVBS;
      ref_mult_q    <= `VFC_MULT_CVBS;
      fmt_seen_q    <= `VFC_FMT_CVBS;
      settle_q      <= 7'h00;
      adc_run_q     <= 1'b0;
    end else begin
      power_down_q <= ~pd_n_s; // [RULE_04]
      chan_sel_q   <= input_q[`VFC_CHAN_LSB +: 3]; // [RULE_07]
      fmt_seen_q   <= fmt;
      if (fmt != fmt_seen_q) begin
        adc_run_q     <= 1'b0; // [RULE_15]
        adc_clk_sel_q <= fmt; // [RULE_05]
        ref_mult_q    <= fmt_mult(fmt); // [RULE_06]
        settle_q      <= `VFC_SETTLE_CYC;
      end else if (settle_q != 7'h00) begin
        settle_q  <= settle_q - 7'h01;
        adc_run_q <= 1'b0;
      end else begin
        adc_run_q <= ~power_down_q; // [RULE_04] [RULE_15]
      end
    end
  end

  // ****************************************
  // Gain, clamp and fine clamp
  // ****************************************
  assign prod      = adc_sample * gain_q; // [RULE_08]
  assign gained    = (prod[17:16] != 2'b00) ? 10'h3FF : prod[15:6];
  assign clamp_use = ctrl_q[`VFC_CLP_BYP_BIT] ? {mclamp_q, 2'b00} : clamp_q; // [RULE_09]

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_q      <= `VFC_GAIN_UNITY;
      clamp_q     <= 10'h000;
      peak_q      <= 10'h000;
      floor_q     <= 10'h3FF;
      afe_data_q  <= 10'h000;
      afe_valid_q <= 1'b0;
    end else begin
      afe_valid_q <= adc_valid & adc_run_q;
      if (adc_valid & adc_run_q) begin
        afe_data_q <= sat_sub(gained, clamp_use, `VFC_BLACK_LEVEL); // [RULE_10]
        if (gained > peak_q) begin
          peak_q <= gained;
        end
        if (adc_sample < floor_q) begin
          floor_q <= adc_sample;
        end
      end
      if (ctrl_q[`VFC_AGC_BYP_BIT]) begin
        gain_q <= mgain_q; // [RULE_09]
      end else if (line_sync) begin
        if (peak_q > `VFC_AGC_TARGET && gain_q != 8'h01) begin
          gain_q <= gain_q - 8'h01;
        end else if (peak_q < `VFC_AGC_TARGET && gain_q != 8'hFF) begin
          gain_q <= gain_q + 8'h01;
        end
      end
      if (line_sync) begin
        clamp_q <= floor_q;
        peak_q  <= 10'h000;
        floor_q <= 10'h3FF;
      end
    end
  end

  // ****************************************
  // Standard detection
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lines_q <= 10'h000;
      std_q   <= `VFC_STD_NONE;
    end else if (power_down_q) begin
      lines_q <= 10'h000;
      std_q   <= `VFC_STD_NONE;
    end else if (field_sync) begin
      lines_q <= 10'h000;
      if (lines_q > `VFC_LINES_625) begin // [RULE_13]
        std_q <= secam_carrier ? `VFC_STD_SECAM : `VFC_STD_PAL;
      end else if (lines_q != 10'h000) begin
        std_q <= `VFC_STD_NTSC;
      end
    end else if (line_sync && lines_q != 10'h3FF) begin
      lines_q <= lines_q + 10'h001;
    end
  end

  // ****************************************
  // 4:2:2 output with down-dither
  // ****************************************
  assign fmt_byte = pend_q ? pend_y_q : c_in;

  vfc_dither u_dither (
    .clk  (clk),
    .rstn (rstn),
    .step (vid_valid_q),
    .din  (fmt_byte),
    .dout (dith6)
  );

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_y_q    <= 8'h00;
      pend_q      <= 1'b0;
      cr_q        <= 1'b0;
      vid_data_q  <= 8'h00;
      vid_valid_q <= 1'b0;
      vid_luma_q  <= 1'b0;
    end else if (power_down_q) begin
      pend_q      <= 1'b0;
      cr_q        <= 1'b0;
      vid_valid_q <= 1'b0;
    end else begin
      vid_valid_q <= pend_q | pix_valid;
      vid_luma_q  <= pend_q;
      if (pend_q | pix_valid) begin
        if (ctrl_q[`VFC_DITHER_BIT]) begin
          vid_data_q <= {dith6, 2'b00}; // [RULE_12]
        end else begin
          vid_data_q <= fmt_byte; // [RULE_11]
        end
      end
      if (pend_q) begin
        pend_q <= 1'b0;
      end else if (pix_valid) begin
        pend_y_q <= y_in; // [RULE_11]
        pend_q   <= 1'b1;
        cr_q     <= ~cr_q;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/vfc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfc_defs.vh"
module vfc_chk (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       serial_data_pin_o_q,
  input wire logic       power_down_pin_n,
  input wire logic [2:0] chan_sel_q,
  input wire logic [1:0] adc_clk_sel_q,
  input wire logic [3:0] ref_mult_q,
  input wire logic       adc_run_q,
  input wire logic       pix_valid,
  input wire logic       vid_valid_q,
  input wire logic       vid_luma_q,
  input wire logic       power_down_q
);
  logic [7:0] gap_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****
  // Cycles since last rate change
  // ****
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 8'hFF;
    end else if ($changed(adc_clk_sel_q)) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_q + {7'h00, gap_q != 8'hFF};
    end
  end
  // ****
  // Assertions
  // ****
  a_sda_open_drain: assert property (!serial_data_pin_o_q)
    else $error("data driven");
  a_pdn_enters: assert property ((!power_down_pin_n) [*5] |-> power_down_q)
    else $error("no power-down");
  a_pdn_stops_adc: assert property (power_down_q [*2] |-> !adc_run_q)
    else $error("adc runs");
  a_rate_mult: assert property (adc_clk_sel_q != 2'h3 && ref_mult_q ==
    (adc_clk_sel_q == `VFC_FMT_CVBS ? `VFC_MULT_CVBS :
     adc_clk_sel_q == `VFC_FMT_YC ? `VFC_MULT_YC : `VFC_MULT_YPRPB))
    else $error("bad multiplier");
  a_chan_follow: assert property (reg_wr && reg_addr == `VFC_REG_INPUT |->
    ##2 {5'h00, chan_sel_q} == ($past(reg_wdata, 2) & 8'h07))
    else $error("stale channel");
  a_settle_gap: assert property ($changed(adc_clk_sel_q) |-> ##2 (!adc_run_q) [*8])
    else $error("no settle");
  a_settle_len: assert property ($rose(adc_run_q) |-> gap_q >= 8'd95)
    else $error("early resume");
  a_vid_order: assert property (pix_valid && !power_down_q |=>
    vid_valid_q && !vid_luma_q ##1 vid_valid_q && vid_luma_q)
    else $error("byte order");
  a_status_read: assert property (reg_rd && reg_addr == `VFC_REG_STATUS |=>
    reg_rdata_q[5:2] == {$past(adc_clk_sel_q), $past(adc_run_q), $past(power_down_q)})
    else $error("bad status");
endmodule
`default_nettype wire

// ### verif/vfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vfc_host_model #(
  parameter int QTR = 70
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Quarter bit of 70 cycles keeps clock near 357 kHz
  task automatic wait_q();
    repeat (QTR) @(posedge clk);
  endtask
  task automatic start_cond();
    sda_pull <= 1'b1;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask
  task automatic put_bit(input logic b, output logic s);
    sda_pull <= !b;
    wait_q();
    scl <= 1'b1;
    wait_q();
    s = sda_line;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    wait_q();
    scl <= 1'b1;
    wait_q();
    sda_pull <= 1'b0;
    wait_q();
  endtask
endmodule
`default_nettype wire

// ### verif/vfc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfc_defs.vh"
module vfc_top_bench;
  // ****
  // Stimulus and wiring
  // ****
  typedef struct packed {logic [7:0] wdata; logic [3:0] mult;} vfc_row_t;
  vfc_row_t rows [8] = '{'{8'h10, `VFC_MULT_YC}, '{8'h21, `VFC_MULT_YPRPB},
    '{8'h02, `VFC_MULT_CVBS}, '{8'h13, `VFC_MULT_YC}, '{8'h24, `VFC_MULT_YPRPB},
    '{8'h05, `VFC_MULT_CVBS}, '{8'h16, `VFC_MULT_YC}, '{8'h27, `VFC_MULT_YPRPB}};
  logic [7:0] rst_addr [6] = '{`VFC_REG_INPUT, `VFC_REG_CTRL, `VFC_REG_MGAIN,
    `VFC_REG_MCLAMP, `VFC_REG_ID, 8'h07};
  logic [7:0] rst_exp [6] = '{`VFC_INPUT_RST, `VFC_CTRL_RST, `VFC_MGAIN_RST,
    `VFC_MCLAMP_RST, `VFC_ID_VAL, 8'h00};
  logic [1:0] std_exp [3] = '{`VFC_STD_NTSC, `VFC_STD_PAL, `VFC_STD_SECAM};
  logic       clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, adc_valid = 1'b0;
  logic       line_sync = 1'b0, field_sync = 1'b0, secam_carrier = 1'b0, pix_valid = 1'b0;
  logic       address_select_pin = 1'b0, power_down_pin_n = 1'b1, ack;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, y_in = 8'h00, c_in = 8'h00, val;
  logic [9:0] adc_sample = 10'h000;
  logic [6:0] exp_f;
  int         bad_count = 0, tests_run = 0, cycles = 0, i;
  wire logic [7:0] reg_rdata_q, vid_data_q;
  wire logic [9:0] afe_data_q;
  wire logic [3:0] ref_mult_q;
  wire logic [2:0] chan_sel_q;
  wire logic [1:0] adc_clk_sel_q;
  wire logic       serial_data_pin_o_q, serial_data_pin_oe_q, afe_valid_q, vid_valid_q;
  wire logic       vid_luma_q, adc_run_q, power_down_q, scl_pin, host_pull, serial_data_pin_i;
  assign serial_data_pin_i = !(serial_data_pin_oe_q | host_pull);
  vfc_top DUT (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .scl_pin(scl_pin),
    .serial_data_pin_i(serial_data_pin_i), .serial_data_pin_o_q(serial_data_pin_o_q),
    .serial_data_pin_oe_q(serial_data_pin_oe_q), .address_select_pin(address_select_pin),
    .power_down_pin_n(power_down_pin_n), .chan_sel_q(chan_sel_q),
    .adc_clk_sel_q(adc_clk_sel_q), .ref_mult_q(ref_mult_q), .adc_run_q(adc_run_q),
    .adc_sample(adc_sample), .adc_valid(adc_valid), .afe_data_q(afe_data_q),
    .afe_valid_q(afe_valid_q), .line_sync(line_sync), .field_sync(field_sync),
    .secam_carrier(secam_carrier), .y_in(y_in), .c_in(c_in), .pix_valid(pix_valid),
    .vid_data_q(vid_data_q), .vid_valid_q(vid_valid_q), .vid_luma_q(vid_luma_q),
    .power_down_q(power_down_q)
  );
  vfc_host_model host (.clk(clk), .sda_line(serial_data_pin_i), .scl(scl_pin),
    .sda_pull(host_pull));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 val = reg_rdata_q;
    @(posedge clk);
  endtask
  task automatic vid_byte(input logic [7:0] exp, input logic luma, dith);
    logic [5:0] diff;
    @(posedge clk);
    pix_valid <= 1'b0;
    #1 diff = vid_data_q[7:2] - exp[7:2];
    chk("byte kind", {vid_valid_q, vid_luma_q}, {1'b1, luma});
    if (dith) begin
      chk("dither", {vid_data_q[1:0], diff < 6'h02 || diff == 6'h3F}, 3'h1);
    end else begin
      chk("byte", vid_data_q, exp);
    end
  endtask
  task automatic pixel(input logic [7:0] y, c, input logic dith);
    y_in <= y;
    c_in <= c;
    pix_valid <= 1'b1;
    vid_byte(c, 1'b0, dith);
    vid_byte(y, 1'b1, dith);
  endtask
  task automatic field(input int n);
    repeat (n) begin
      line_sync <= 1'b1;
      @(posedge clk);
      line_sync <= 1'b0;
      @(posedge clk);
    end
    field_sync <= 1'b1;
    @(posedge clk);
    field_sync <= 1'b0;
    @(posedge clk);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    tick(10);
    chk("reset outputs", {ref_mult_q, power_down_q, serial_data_pin_oe_q}, 6'h0A);
    tick(10);
    rstn <= 1'b1; // Held low 20 cycles
    tick(6);
    chk("power up", power_down_q, 1'b0);
    for (i = 0; i < 6; i++) begin
      rd(rst_addr[i]);
      chk("reset value", val, rst_exp[i]);
    end
    wr(`VFC_REG_ID, 8'hA5);
    rd(`VFC_REG_ID);
    chk("id read only", val, `VFC_ID_VAL);
    $display("registers done");
    for (i = 0; i < 8; i++) begin
      wr(`VFC_REG_INPUT, rows[i].wdata);
      #1 chk("settle", adc_run_q, 1'b0);
      tick(110);
      exp_f = {rows[i].wdata[5:4], rows[i].mult, 1'b1};
      #1 chk("channel", chan_sel_q, rows[i].wdata[2:0]);
      chk("format", {adc_clk_sel_q, ref_mult_q, adc_run_q}, exp_f);
    end
    $display("formats done");
    wr(`VFC_REG_CTRL, 8'h03);
    wr(`VFC_REG_MGAIN, `VFC_GAIN_UNITY);
    for (i = 0; i < 2; i++) begin
      wr(`VFC_REG_MCLAMP, i ? 8'h00 : 8'h10);
      adc_sample <= 10'h2AB;
      adc_valid <= 1'b1;
      @(posedge clk);
      adc_valid <= 1'b0;
      #1 chk("clamp valid", afe_valid_q, 1'b1);
      chk("fine clamp", afe_data_q, i ? 10'h2EB : 10'h2AB);
    end
    $display("clamp done");
    for (i = 0; i < 2; i++) begin
      wr(`VFC_REG_CTRL, i ? 8'h07 : 8'h03);
      pixel(8'h5E, 8'hB7, i[0]);
      pixel(8'hEB, 8'h10, i[0]);
    end
    $display("video done");
    power_down_pin_n <= 1'b0;
    tick(6);
    pix_valid <= 1'b1;
    @(posedge clk);
    pix_valid <= 1'b0;
    #1 chk("down state", {power_down_q, adc_run_q, vid_valid_q}, 3'b100);
    @(posedge clk);
    #1 chk("down stream", vid_valid_q, 1'b0);
    power_down_pin_n <= 1'b1;
    tick(4);
    #1 chk("wake", {power_down_q, adc_run_q}, 2'b01);
    $display("power-down done");
    for (i = 0; i < 3; i++) begin
      secam_carrier <= i == 2;
      field(0);
      field(i ? 625 : 525);
      field(i ? 625 : 525);
      rd(`VFC_REG_STATUS);
      chk("standard", val[1:0], std_exp[i]);
    end
    $display("standard done");
    tick(500);
    host.start_cond();
    host.put_byte(8'h40, ack);
    chk("ack low address", ack, 1'b1);
    host.put_byte(`VFC_REG_INPUT, ack);
    host.put_byte(8'h21, ack);
    host.stop_cond();
    tick(4);
    chk("serial write", {ack, chan_sel_q}, 4'h9);
    address_select_pin <= 1'b1;
    for (i = 0; i < 2; i++) begin
      host.start_cond();
      host.put_byte(i ? 8'h42 : 8'h40, ack);
      chk("address select", ack, i[0]);
      if (i) begin
        host.put_byte(`VFC_REG_MCLAMP, ack);
        host.put_byte(8'h2C, ack);
      end
      host.stop_cond();
    end
    rd(`VFC_REG_MCLAMP);
    chk("serial clamp", val, 8'h2C);
    $display("serial done");
    finish_test();
  end
endmodule
bind vfc_top vfc_chk u_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .serial_data_pin_o_q(serial_data_pin_o_q),
  .power_down_pin_n(power_down_pin_n), .chan_sel_q(chan_sel_q),
  .adc_clk_sel_q(adc_clk_sel_q), .ref_mult_q(ref_mult_q), .adc_run_q(adc_run_q),
  .pix_valid(pix_valid), .vid_valid_q(vid_valid_q), .vid_luma_q(vid_luma_q),
  .power_down_q(power_down_q)
);
`default_nettype wire
